// *** inc/ast_pkg.sv ***
// Constants, command layout and state record of the ALU status and table
// transfer block.
// Assumes a 32-bit APB master and one 20 MHz core clock.
package ast_pkg;

    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_WORK   = 8'h08;
    localparam logic [7:0] OFS_FILE   = 8'h0C;
    localparam logic [7:0] OFS_CMD    = 8'h10;
    localparam logic [7:0] OFS_PTR    = 8'h14;
    localparam logic [7:0] OFS_LATCH  = 8'h18;
    localparam logic [7:0] OFS_MODE   = 8'h1C;

    // ==================================================================
    // Status bit positions and reset values
    localparam int BIT_C  = 0;
    localparam int BIT_DC = 1;
    localparam int BIT_Z  = 2;
    localparam int BIT_OV = 3;
    localparam logic [7:0] STATUS_RST = 8'hF0;
    localparam logic [7:0] FLAG_MASK  = 8'h07;
    localparam logic [7:0] ARITH_MASK = 8'h0F;
    localparam logic [7:0] CLR_MASK   = 8'hF0;
    localparam int MODE_BUSY_BIT = 8;

    // ==================================================================
    // Operating modes
    localparam logic [1:0] MODE_MPU  = 2'h0;
    localparam logic [1:0] MODE_MCU  = 2'h1;
    localparam logic [1:0] MODE_EXT  = 2'h2;
    localparam logic [1:0] MODE_PROT = 2'h3;

    // ==================================================================
    // Operations and destinations
    localparam logic [3:0] OP_ADD  = 4'h0;
    localparam logic [3:0] OP_SUB  = 4'h1;
    localparam logic [3:0] OP_AND  = 4'h2;
    localparam logic [3:0] OP_IOR  = 4'h3;
    localparam logic [3:0] OP_XOR  = 4'h4;
    localparam logic [3:0] OP_INC  = 4'h5;
    localparam logic [3:0] OP_DEC  = 4'h6;
    localparam logic [3:0] OP_CLR  = 4'h7;
    localparam logic [3:0] OP_MOV  = 4'h8;
    localparam logic [3:0] OP_TABLE_LATCH_WRITE = 4'h9;
    localparam logic [3:0] OP_TBWT = 4'hA;
    localparam logic [3:0] OP_TABLE_LATCH_READ = 4'hB;
    localparam logic [3:0] OP_TBRD = 4'hC;
    localparam logic [1:0] DST_WORK   = 2'h0;
    localparam logic [1:0] DST_FILE   = 2'h1;
    localparam logic [1:0] DST_STATUS = 2'h2;

    // ==================================================================
    // Types
    typedef struct packed {
        logic [7:0] imm;
        logic [5:0] rsv1;
        logic [1:0] dest;
        logic       rsv0;
        logic       inc;
        logic       hi;
        logic       src_sel;
        logic [3:0] op;
    } ast_cmd_s;

    typedef enum logic [1:0] {ST_IDLE, ST_MEM_RD, ST_EXT} ast_state_e;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  work;
        logic [7:0]  file;
        logic [15:0] ptr;
        logic [15:0] latch;
        logic [1:0]  mode;
        ast_cmd_s    cmd;
        ast_state_e  st;
        logic [7:0]  cnt;
        logic [31:0] prdata;
        logic        pslverr;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] ext_addr;
        logic [15:0] ext_wdata;
        logic        ext_we;
        logic        ext_oe;
    } ast_state_s;

endpackage : ast_pkg

// *** logic/ast_core.sv ***
// ALU status register and table transfer path, reached over APB.
// Assumes an external program memory that answers within the wait count.
//
// Function
// - One register holds flags and pointer modes.
// - Flag-updating ops override written Z, DC, C.
// - Clear to status: zero modes, set Z.
// - Subtract carries mean no borrow.
// - Overflow on signed result out of range.
// - Single-operand source: working or file register.
// - Two-operand: working plus file or immediate.
// - Program words move as two byte transfers.
// - Two table-write operations into program memory.
// - Two table-read operations out of memory.
// - External memory only in external modes.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module ast_core #(
    parameter int PM_AW    = 12,
    parameter int EXT_WAIT = 4
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    output      logic [15:0] ext_addr,
    output      logic [15:0] ext_wdata,
    output      logic        ext_we,
    output      logic        ext_oe,
    input  wire logic [15:0] ext_rdata
);

    // ==================================================================
    // State and program memory
    localparam logic [7:0] WAIT_CNT = 8'(EXT_WAIT);
    localparam int PM_DEPTH = 1 << PM_AW;

    ast_pkg::ast_state_s q;
    ast_pkg::ast_state_s n;
    logic [15:0]         pmem [PM_DEPTH];
    logic [15:0]         pmem_q;
    logic                mem_we;
    logic [PM_AW-1:0]    mem_addr;

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            pmem[mem_addr] <= q.latch;
        end
        pmem_q <= pmem[mem_addr];
    end

    // ==================================================================
    // ALU
    function automatic logic [11:0] alu_calc(
        input logic [3:0] op,
        input logic [7:0] x,
        input logic [7:0] y
    );
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] r;
        logic       v;
        sum = 9'h000;
        nib = 5'h00;
        r   = 8'h00;
        v   = 1'b0;
        case (op)
            ast_pkg::OP_ADD, ast_pkg::OP_SUB, ast_pkg::OP_INC,
            ast_pkg::OP_DEC: begin
                sum = {1'b0, x} + {1'b0, y} + 9'(op == ast_pkg::OP_SUB
                      || op == ast_pkg::OP_INC);
                nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} +
                      5'(op == ast_pkg::OP_SUB || op == ast_pkg::OP_INC);
                r = sum[7:0];
                v = (x[7] == y[7]) && (r[7] != x[7]);
            end
            ast_pkg::OP_AND: r = x & y;
            ast_pkg::OP_IOR: r = x | y;
            ast_pkg::OP_XOR: r = x ^ y;
            ast_pkg::OP_MOV: r = y;
            default:         r = 8'h00;
        endcase
        // Result, then V, Z, DC and C.
        alu_calc = {r, v, (r == 8'h00), nib[4], sum[8]};
    endfunction : alu_calc

    // ==================================================================
    // Next state
    ast_pkg::ast_cmd_s cmd_w;
    logic              hit;
    logic              bus_wr;
    logic              busy;
    logic              is_ext;
    logic [7:0]        src_x;
    logic [7:0]        src_y;
    logic [11:0]       alu;
    logic [7:0]        wmask;
    logic [7:0]        fmask;
    logic [7:0]        flags;
    logic [15:0]       next_ptr;
    logic [7:0]        rd_val_lo;

    always_comb begin
        n         = q;
        mem_we    = 1'b0;
        mem_addr  = q.ptr[PM_AW-1:0];
        cmd_w     = ast_pkg::ast_cmd_s'(pwdata[23:0]);
        busy      = (q.st != ast_pkg::ST_IDLE);
        bus_wr    = psel && penable && pwrite;
        src_x     = 8'h00;
        src_y     = 8'h00;
        alu       = 12'h000;
        wmask     = 8'hFF;
        fmask     = 8'h00;
        flags     = 8'h00;
        rd_val_lo = 8'h00;
        next_ptr  = q.ptr + 16'h0001;
        // Microprocessor mode sees only the outside memory; extended mode
        // goes outside above the internal array.
        is_ext = (q.mode == ast_pkg::MODE_MPU) ||
                 (q.mode == ast_pkg::MODE_EXT &&
                  (q.ptr >> PM_AW) != 16'h0000);
        hit = (paddr == ast_pkg::OFS_STATUS) || (paddr == ast_pkg::OFS_WORK)
            || (paddr == ast_pkg::OFS_FILE) || (paddr == ast_pkg::OFS_CMD)
            || (paddr == ast_pkg::OFS_PTR) || (paddr == ast_pkg::OFS_LATCH)
            || (paddr == ast_pkg::OFS_MODE);
        n.sync1 = ext_rdata;
        n.sync2 = q.sync1;
        n.ext_we = 1'b0;
        n.ext_oe = 1'b0;

        // Read data and error are latched in the setup phase.
        if (psel && !penable) begin
            n.pslverr = !hit || (pwrite && busy &&
                                 paddr == ast_pkg::OFS_CMD);
            case (paddr)
                ast_pkg::OFS_STATUS: n.prdata = {24'h0000_00, q.status};
                ast_pkg::OFS_WORK:   n.prdata = {24'h0000_00, q.work};
                ast_pkg::OFS_FILE:   n.prdata = {24'h0000_00, q.file};
                ast_pkg::OFS_CMD:    n.prdata = {8'h00, q.cmd};
                ast_pkg::OFS_PTR:    n.prdata = {16'h0000, q.ptr};
                ast_pkg::OFS_LATCH:  n.prdata = {16'h0000, q.latch};
                ast_pkg::OFS_MODE: begin
                    n.prdata = {30'h000_0000, q.mode};
                    n.prdata[ast_pkg::MODE_BUSY_BIT] = busy;
                end
                default:             n.prdata = 32'h0000_0000;
            endcase
        end

        if (bus_wr) begin
            case (paddr)
                ast_pkg::OFS_STATUS: n.status = pwdata[7:0];
                ast_pkg::OFS_WORK:   n.work   = pwdata[7:0];
                ast_pkg::OFS_FILE:   n.file   = pwdata[7:0];
                ast_pkg::OFS_PTR:    n.ptr    = pwdata[15:0];
                ast_pkg::OFS_LATCH:  n.latch  = pwdata[15:0];
                ast_pkg::OFS_MODE:   n.mode   = pwdata[1:0];
                default: ;
            endcase
        end

        // A command refused in its setup cycle stays refused, so the error
        // answer and the action always agree.
        if (bus_wr && paddr == ast_pkg::OFS_CMD && !q.pslverr) begin
            n.cmd = cmd_w;
            rd_val_lo = cmd_w.hi ? q.latch[15:8] : q.latch[7:0];
            case (cmd_w.op)
                ast_pkg::OP_ADD, ast_pkg::OP_SUB, ast_pkg::OP_AND,
                ast_pkg::OP_IOR, ast_pkg::OP_XOR, ast_pkg::OP_MOV: begin
                    src_x = q.work;
                    src_y = cmd_w.src_sel ? cmd_w.imm : q.file;
                    if (cmd_w.op == ast_pkg::OP_SUB) begin
                        // Source minus working, by adding the complement.
                        src_x = src_y;
                        src_y = ~q.work;
                    end
                end
                default: begin
                    src_x = cmd_w.src_sel ? q.work : q.file;
                    src_y = (cmd_w.op == ast_pkg::OP_DEC) ? 8'hFF : 8'h00;
                end
            endcase
            alu = alu_calc(cmd_w.op, src_x, src_y);
            case (cmd_w.op)
                ast_pkg::OP_ADD, ast_pkg::OP_SUB, ast_pkg::OP_INC,
                ast_pkg::OP_DEC: fmask = ast_pkg::ARITH_MASK;
                ast_pkg::OP_AND, ast_pkg::OP_IOR, ast_pkg::OP_XOR,
                ast_pkg::OP_CLR: fmask = 8'h01 << ast_pkg::BIT_Z;
                default:         fmask = 8'h00;
            endcase
            flags = {4'h0, alu[3:0]};
            if (cmd_w.op <= ast_pkg::OP_MOV) begin
                n.status = (q.status & ~fmask) | (flags & fmask);
                case (cmd_w.dest)
                    ast_pkg::DST_WORK: n.work = alu[11:4];
                    ast_pkg::DST_FILE: n.file = alu[11:4];
                    ast_pkg::DST_STATUS: begin
                        if ((fmask & ast_pkg::FLAG_MASK) != 8'h00) begin
                            wmask = ~ast_pkg::FLAG_MASK;
                        end
                        if (cmd_w.op == ast_pkg::OP_CLR) begin
                            wmask = ast_pkg::CLR_MASK;
                        end
                        n.status = (alu[11:4] & wmask) |
                                   (n.status & ~wmask);
                    end
                    default: ;
                endcase
            end else begin
                // Each table operation moves one byte of the 16-bit word.
                case (cmd_w.op)
                    ast_pkg::OP_TABLE_LATCH_WRITE, ast_pkg::OP_TBWT: begin
                        if (cmd_w.hi) begin
                            n.latch[15:8] = q.file;
                        end else begin
                            n.latch[7:0] = q.file;
                        end
                        if (cmd_w.op == ast_pkg::OP_TBWT) begin
                            n.st = is_ext ? ast_pkg::ST_EXT
                                          : ast_pkg::ST_MEM_RD;
                            n.cnt = WAIT_CNT;
                            n.ext_addr  = q.ptr;
                            n.ext_wdata = n.latch;
                            n.ext_we    = is_ext;
                        end
                    end
                    ast_pkg::OP_TABLE_LATCH_READ, ast_pkg::OP_TBRD: begin
                        n.file = rd_val_lo;
                        if (cmd_w.op == ast_pkg::OP_TBRD) begin
                            n.st = is_ext ? ast_pkg::ST_EXT
                                          : ast_pkg::ST_MEM_RD;
                            n.cnt = WAIT_CNT;
                            n.ext_addr = q.ptr;
                            n.ext_oe   = is_ext;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Table word access; the internal memory is written a cycle later so
        // that the write sees the latch with the merged byte.
        case (q.st)
            ast_pkg::ST_IDLE: ;
            ast_pkg::ST_MEM_RD: begin
                if (q.cmd.op == ast_pkg::OP_TBWT) begin
                    mem_we = 1'b1;
                    n.st = ast_pkg::ST_IDLE;
                    if (q.cmd.inc) begin
                        n.ptr = next_ptr;
                    end
                end else if (q.cnt == WAIT_CNT) begin
                    n.cnt = 8'h00;
                end else begin
                    n.latch = pmem_q;
                    n.st = ast_pkg::ST_IDLE;
                    if (q.cmd.inc) begin
                        n.ptr = next_ptr;
                    end
                end
            end
            ast_pkg::ST_EXT: begin
                // The strobe is held for the whole wait so a slow outside
                // memory sees a stable address.
                n.ext_we = (q.cmd.op == ast_pkg::OP_TBWT);
                n.ext_oe = (q.cmd.op == ast_pkg::OP_TBRD);
                n.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    n.ext_we = 1'b0;
                    n.ext_oe = 1'b0;
                    n.st = ast_pkg::ST_IDLE;
                    if (q.cmd.op == ast_pkg::OP_TBRD) begin
                        n.latch = q.sync2;
                    end
                    if (q.cmd.inc) begin
                        n.ptr = next_ptr;
                    end
                end
            end
            default: n.st = ast_pkg::ST_IDLE;
        endcase
    end

    // ==================================================================
    // State register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.status <= ast_pkg::STATUS_RST;
            q.mode <= ast_pkg::MODE_MPU;
            q.st <= ast_pkg::ST_IDLE;
        end else begin
            q <= n;
        end
    end

    // ==================================================================
    // Outputs
    assign prdata    = q.prdata;
    assign pslverr   = q.pslverr;
    assign pready    = 1'b1;
    assign ext_addr  = q.ext_addr;
    assign ext_wdata = q.ext_wdata;
    assign ext_we    = q.ext_we;
    assign ext_oe    = q.ext_oe;

endmodule : ast_core

// *** dv/ast_chk.sv ***
// Assertion checker for the ALU status and table transfer block.
// Assumes it is bound to ast_core and sees only that module's ports.
`timescale 1ns/10ps
module ast_chk #(
    parameter int EXT_WAIT = 4
) (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    input wire logic        ext_we,
    input wire logic        ext_oe,
    input wire logic [15:0] ext_rdata
);
    // ==================================================================
    // Helpers
    logic [7:0] strobe_len;
    logic       setup;
    logic       mapped;
    logic       strobe;
    assign setup  = psel && !penable;
    assign strobe = ext_oe || ext_we;
    assign mapped = paddr[1:0] == 2'h0 && paddr >= 8'h04 && paddr <= 8'h1C;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_len <= 8'h00;
        end else begin
            strobe_len <= strobe ? strobe_len + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_st_wr;
        psel && penable && pwrite && paddr == ast_pkg::OFS_STATUS;
    endsequence
    sequence s_st_rd;
        setup && !pwrite && paddr == ast_pkg::OFS_STATUS;
    endsequence
    // ==================================================================
    // Properties
    chk_status_readback: assert property (s_st_wr ##2 s_st_rd |=>
        prdata == {24'h00_0000, $past(pwdata[7:0], 3)})
        else $error("status readback differs");
    chk_strobe_cause: assert property ($rose(strobe) |->
        $past(psel && penable && pwrite && paddr == ast_pkg::OFS_CMD))
        else $error("memory strobe without command");
    chk_strobe_excl: assert property (!(ext_oe && ext_we))
        else $error("read and write strobes together");
    chk_strobe_hold: assert property (strobe && strobe_len != 8'h00
        |-> $stable(ext_addr) && $stable(ext_wdata))
        else $error("memory address or data moved");
    chk_strobe_len: assert property (!strobe && strobe_len != 8'h00
        |-> strobe_len == EXT_WAIT)
        else $error("memory strobe length wrong");
    chk_unmapped_err: assert property (setup && !mapped |=>
        pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (setup && mapped &&
        paddr != ast_pkg::OFS_CMD |=> !pslverr)
        else $error("mapped access refused");
    chk_reserved_zero: assert property (s_st_rd |=>
        prdata[31:8] == 24'h00_0000)
        else $error("status upper bits not zero");
    chk_pready_high: assert property (psel && penable |-> pready)
        else $error("access phase stalled");
endmodule : ast_chk
bind ast_core ast_chk #(.EXT_WAIT(EXT_WAIT)) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_oe(ext_oe),
    .ext_rdata(ext_rdata));

// *** dv/tb_top.sv ***
// Self-checking bench for the ALU status and table transfer block.
// Assumes the checker is bound in and every register is one APB word.
`timescale 1ns/10ps
module tb_top;
    // ==================================================================
    // Signals
    logic        sys_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [15:0] ext_rdata = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_we;
    logic        ext_oe;
    logic [15:0] ext_addr;
    logic [15:0] ext_wdata;
    logic [15:0] seen_addr;
    logic [15:0] seen_wdata;
    logic        we_seen   = 1'b0;
    logic        oe_seen   = 1'b0;
    logic [31:0] q;
    logic        e;
    int          error_cnt = 0;
    int          checked   = 0;
    always #25 sys_clk = ~sys_clk;
    // A small internal memory keeps the extended-mode boundary cheap.
    ast_core #(.PM_AW(4), .EXT_WAIT(4)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_oe(ext_oe),
        .ext_rdata(ext_rdata));
    always @(posedge sys_clk) begin
        if (ext_oe) begin
            oe_seen   <= 1'b1;
            seen_addr <= ext_addr;
        end
        if (ext_we) begin
            we_seen    <= 1'b1;
            seen_wdata <= ext_wdata;
        end
    end
    // ==================================================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, q, exp);
    endtask : rdc
    task automatic run(input logic [3:0] op, input logic s, input logic h,
                       input logic i, input logic [1:0] dst,
                       input logic [7:0] imm);
        ast_pkg::ast_cmd_s c;
        c = '0;
        c.op = op;
        c.src_sel = s;
        c.hi = h;
        c.inc = i;
        c.dest = dst;
        c.imm = imm;
        wr(ast_pkg::OFS_CMD, {8'h00, c});
    endtask : run
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, ast_pkg::OFS_MODE, 32'h0000_0000);
            n++;
        end while (q[8] !== 1'b0 && n < 40);
        if (q[8] !== 1'b0) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : wait_idle
    // ==================================================================
    // Scenarios
    task automatic t_reset();
        rdc("status rst", ast_pkg::OFS_STATUS, 32'h0000_00F0);
        rdc("mode rst", ast_pkg::OFS_MODE, 32'h0000_0000);
        rdc("unmapped rd", 8'h20, 32'h0000_0000);
        check("unmapped err", {31'h0, e}, 32'h1);
    endtask : t_reset
    task automatic t_alu();
        wr(ast_pkg::OFS_WORK, 32'h0000_007F);
        wr(ast_pkg::OFS_FILE, 32'h0000_0001);
        run(ast_pkg::OP_ADD, 1'b0, 1'b0, 1'b0, ast_pkg::DST_WORK, 8'h00);
        rdc("add work", ast_pkg::OFS_WORK, 32'h0000_0080);
        rdc("add flags", ast_pkg::OFS_STATUS, 32'h0000_00FA);
        wr(ast_pkg::OFS_FILE, 32'h0000_00FF);
        run(ast_pkg::OP_INC, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        rdc("inc file", ast_pkg::OFS_FILE, 32'h0000_0000);
        rdc("inc flags", ast_pkg::OFS_STATUS, 32'h0000_00F7);
        run(ast_pkg::OP_INC, 1'b1, 1'b0, 1'b0, ast_pkg::DST_WORK, 8'h00);
        rdc("inc work", ast_pkg::OFS_WORK, 32'h0000_0081);
        rdc("inc clear", ast_pkg::OFS_STATUS, 32'h0000_00F0);
    endtask : t_alu
    task automatic t_sub();
        wr(ast_pkg::OFS_WORK, 32'h0000_0001);
        run(ast_pkg::OP_SUB, 1'b1, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h80);
        rdc("sub file", ast_pkg::OFS_FILE, 32'h0000_007F);
        rdc("sub ovf", ast_pkg::OFS_STATUS, 32'h0000_00F9);
        run(ast_pkg::OP_SUB, 1'b1, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        rdc("sub borrow", ast_pkg::OFS_STATUS, 32'h0000_00F0);
        run(ast_pkg::OP_SUB, 1'b1, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h01);
        rdc("sub zero", ast_pkg::OFS_STATUS, 32'h0000_00F7);
    endtask : t_sub
    task automatic t_dest();
        run(ast_pkg::OP_ADD, 1'b1, 1'b0, 1'b0, ast_pkg::DST_STATUS, 8'h01);
        rdc("add to status", ast_pkg::OFS_STATUS, 32'h0000_0000);
        wr(ast_pkg::OFS_STATUS, 32'h0000_00FB);
        rdc("status write", ast_pkg::OFS_STATUS, 32'h0000_00FB);
        run(ast_pkg::OP_CLR, 1'b0, 1'b0, 1'b0, ast_pkg::DST_STATUS, 8'h00);
        rdc("clr status", ast_pkg::OFS_STATUS, 32'h0000_000F);
        run(ast_pkg::OP_MOV, 1'b1, 1'b0, 1'b0, ast_pkg::DST_STATUS, 8'h35);
        rdc("mov status", ast_pkg::OFS_STATUS, 32'h0000_0035);
    endtask : t_dest
    task automatic t_table();
        wr(ast_pkg::OFS_MODE, {30'h0, ast_pkg::MODE_MCU});
        wr(ast_pkg::OFS_PTR, 32'h0000_0003);
        wr(ast_pkg::OFS_FILE, 32'h0000_00AB);
        run(ast_pkg::OP_TABLE_LATCH_WRITE, 1'b0, 1'b1, 1'b0, ast_pkg::DST_FILE, 8'h00);
        wr(ast_pkg::OFS_FILE, 32'h0000_00CD);
        run(ast_pkg::OP_TBWT, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        wait_idle();
        wr(ast_pkg::OFS_LATCH, 32'h0000_0000);
        run(ast_pkg::OP_TBRD, 1'b0, 1'b0, 1'b1, ast_pkg::DST_FILE, 8'h00);
        wait_idle();
        rdc("word", ast_pkg::OFS_LATCH, 32'h0000_ABCD);
        rdc("ptr inc", ast_pkg::OFS_PTR, 32'h0000_0004);
        run(ast_pkg::OP_TABLE_LATCH_READ, 1'b0, 1'b1, 1'b0, ast_pkg::DST_FILE, 8'h00);
        rdc("latch hi", ast_pkg::OFS_FILE, 32'h0000_00AB);
        check("int quiet", {31'h0, oe_seen | we_seen}, 32'h0);
    endtask : t_table
    task automatic t_ext();
        wr(ast_pkg::OFS_MODE, {30'h0, ast_pkg::MODE_EXT});
        wr(ast_pkg::OFS_PTR, 32'h0000_0020);
        ext_rdata <= 16'h5A3C;
        run(ast_pkg::OP_TBRD, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        run(ast_pkg::OP_TBRD, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        check("busy err", {31'h0, e}, 32'h1);
        wait_idle();
        rdc("ext word", ast_pkg::OFS_LATCH, 32'h0000_5A3C);
        check("ext addr", {16'h0, seen_addr}, 32'h0000_0020);
        wr(ast_pkg::OFS_FILE, 32'h0000_0011);
        run(ast_pkg::OP_TBWT, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        wait_idle();
        check("ext wdata", {16'h0, seen_wdata}, 32'h0000_5A11);
        wr(ast_pkg::OFS_MODE, {30'h0, ast_pkg::MODE_MPU});
        wr(ast_pkg::OFS_PTR, 32'h0000_0003);
        run(ast_pkg::OP_TBRD, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        wait_idle();
        check("mpu ext", {16'h0, seen_addr}, 32'h0000_0003);
    endtask : t_ext
    task automatic t_logic();
        wr(ast_pkg::OFS_WORK, 32'h0000_000F);
        wr(ast_pkg::OFS_FILE, 32'h0000_003C);
        run(ast_pkg::OP_AND, 1'b0, 1'b0, 1'b0, ast_pkg::DST_WORK, 8'h00);
        run(ast_pkg::OP_IOR, 1'b1, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'hF0);
        run(ast_pkg::OP_XOR, 1'b0, 1'b0, 1'b0, ast_pkg::DST_WORK, 8'h00);
        rdc("logic file", ast_pkg::OFS_FILE, 32'h0000_00FC);
        rdc("logic work", ast_pkg::OFS_WORK, 32'h0000_00F0);
        run(ast_pkg::OP_DEC, 1'b0, 1'b0, 1'b0, ast_pkg::DST_WORK, 8'h00);
        rdc("dec work", ast_pkg::OFS_WORK, 32'h0000_00FB);
        rdc("dec flags", ast_pkg::OFS_STATUS, 32'h0000_0033);
        wr(ast_pkg::OFS_MODE, {30'h0, ast_pkg::MODE_PROT});
        wr(ast_pkg::OFS_PTR, 32'h0000_0003);
        run(ast_pkg::OP_TBRD, 1'b0, 1'b0, 1'b0, ast_pkg::DST_FILE, 8'h00);
        wait_idle();
        rdc("prot word", ast_pkg::OFS_LATCH, 32'h0000_ABCD);
    endtask : t_logic
    // ==================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_alu();
        t_sub();
        t_dest();
        t_table();
        t_ext();
        t_logic();
        report_and_stop();
    end
endmodule : tb_top
